// >>> design/dss_device.sv
// Functional notes
// - Alternate tracking and converting phases
// - Start edge holds both channels together
// - Convert held channels one at a time
// - Binary search half down to 1/65536
// - Format results only after all enabled channels converted
// - Quantise span into 65536 levels
// - Span code per channel, per conversion
// - Codes 7,6,3,2 bipolar, two's complement
// - Codes 5,4,1 unipolar, straight binary
// - Disabled channel shortens conversion time
// - Interface type by pin; lane count by pin when not LVDS
// - Optional power-down while idle
// - Host sends both spans as 6-bit word
// - Results with spans out, channel 0 first
`timescale 1ns/1ps
`default_nettype none
module dss_device
	import dss_pkg::*;
(
	// Link to host
	dss_link_if.dev link,
	// Reset
	input wire logic resetn_in,
	// Held samples, analog side
	input wire logic [15:0] held_ch0_in,
	input wire logic [15:0] held_ch1_in,
	// Analog control and interface selects
	output logic track_out,
	output logic [15:0] dac_code_out,
	output logic dac_chan_out,
	output logic analog_on_out,
	output logic lvds_sel_out,
	output logic dual_lane_out
);
	// ==========================================
	// Pin synchronisers
	logic [1:0] cnv_s_r;
	logic cnv_d_r;
	logic [1:0] pd_s_r;
	logic [1:0] mode_s_r;
	logic [1:0] lane_s_r;
	logic cnv_rise;

	always_ff @(posedge link.link_clk or negedge resetn_in) begin
		if (!resetn_in) begin
			cnv_s_r <= '0;
			cnv_d_r <= 1'b0;
			pd_s_r <= '0;
			mode_s_r <= '0;
			lane_s_r <= '0;
		end else begin
			cnv_s_r <= {cnv_s_r[0], link.conv_start};
			cnv_d_r <= cnv_s_r[1];
			pd_s_r <= {pd_s_r[0], link.power_down};
			mode_s_r <= {mode_s_r[0], link.lvds_mode};
			lane_s_r <= {lane_s_r[0], link.two_lanes};
		end
	end
	assign cnv_rise = cnv_s_r[1] && !cnv_d_r;

	// ==========================================
	// Configuration
	logic [5:0] cfg_r;
	logic [5:0] active_cfg_r;

	always_ff @(posedge link.link_clk or negedge resetn_in) begin
		if (!resetn_in) begin
			cfg_r <= DSS_RESET_CFG;
		end else if (link.cfg_valid) begin
			cfg_r <= link.cfg_word;
		end
	end

	always_ff @(posedge link.link_clk or negedge resetn_in) begin
		if (!resetn_in) begin
			lvds_sel_out <= 1'b0;
			dual_lane_out <= 1'b0;
		end else begin
			lvds_sel_out <= mode_s_r[1];
			dual_lane_out <= !mode_s_r[1] && lane_s_r[1];
		end
	end

	// ==========================================
	// Conversion sequencer
	dss_state_e state_r;
	logic chan_r;
	logic [3:0] bit_r;
	logic [15:0] trial_r;
	logic [15:0] sample_r [DSS_CHANS];
	logic [15:0] raw_r [DSS_CHANS];
	logic [18:0] word_r;
	logic push_chan_r;
	logic fifo_ready;
	logic [2:0] span0;
	logic [2:0] span1;
	logic held_val;

	assign span0 = active_cfg_r[2:0];
	assign span1 = active_cfg_r[5:3];
	assign held_val = sample_r[chan_r] >= trial_r;

	always_ff @(posedge link.link_clk or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r <= DSS_IDLE;
			chan_r <= 1'b0;
			bit_r <= DSS_TOP_BIT;
			trial_r <= DSS_FIRST_TRIAL;
			active_cfg_r <= DSS_RESET_CFG;
			push_chan_r <= 1'b0;
			word_r <= '0;
			for (int i = 0; i < DSS_CHANS; i++) begin
				sample_r[i] <= DSS_RESET_CODE;
				raw_r[i] <= DSS_RESET_CODE;
			end
		end else begin
			unique case (state_r)
				DSS_IDLE: begin
					if (pd_s_r[1]) begin
						state_r <= DSS_SLEEP;
					end else if (cnv_rise) begin
						sample_r[0] <= held_ch0_in;
						sample_r[1] <= held_ch1_in;
						active_cfg_r <= cfg_r;
						state_r <= DSS_SAMPLE;
					end
				end
				DSS_SAMPLE: begin
					bit_r <= DSS_TOP_BIT;
					trial_r <= DSS_FIRST_TRIAL;
					if (span0 != DSS_SPAN_OFF) begin
						chan_r <= 1'b0;
						state_r <= DSS_CONVERT;
					end else if (span1 != DSS_SPAN_OFF) begin
						chan_r <= 1'b1;
						state_r <= DSS_CONVERT;
					end else begin
						state_r <= DSS_FORMAT;
					end
					raw_r[0] <= DSS_RESET_CODE;
					raw_r[1] <= DSS_RESET_CODE;
				end
				DSS_CONVERT: begin
					// One trial per cycle: keep or drop the bit, then try the next lower weight
					if (held_val) begin
						raw_r[chan_r] <= trial_r;
					end
					if (bit_r == 4'h0) begin
						if (!chan_r && span1 != DSS_SPAN_OFF) begin
							chan_r <= 1'b1;
							bit_r <= DSS_TOP_BIT;
							trial_r <= DSS_FIRST_TRIAL;
						end else begin
							state_r <= DSS_FORMAT;
						end
					end else begin
						bit_r <= bit_r - 4'h1;
						trial_r <= (held_val ? trial_r : (trial_r & ~(16'h1 << bit_r))) | (16'h1 << (bit_r - 4'h1));
					end
				end
				DSS_FORMAT: begin
					push_chan_r <= 1'b0;
					word_r <= {span0, dss_format(span0, raw_r[0])};
					state_r <= DSS_PUSH;
				end
				DSS_PUSH: begin
					if (fifo_ready) begin
						if (!push_chan_r) begin
							push_chan_r <= 1'b1;
							word_r <= {span1, dss_format(span1, raw_r[1])};
						end else begin
							state_r <= DSS_IDLE;
						end
					end
				end
				DSS_SLEEP: begin
					if (!pd_s_r[1]) begin
						state_r <= DSS_IDLE;
					end
				end
				default: begin
					state_r <= DSS_IDLE;
				end
			endcase
		end
	end

	assign track_out = (state_r == DSS_IDLE);
	assign dac_code_out = trial_r;
	assign dac_chan_out = chan_r;
	assign analog_on_out = (state_r != DSS_SLEEP);
	assign link.busy = !(state_r == DSS_IDLE || state_r == DSS_SLEEP);

	// ==========================================
	// Result queue on the link clock
	dss_fifo #(.WIDTH(DSS_FIFO_W), .DEPTH(DSS_FIFO_D)) u_fifo (
		.clk_in(link.link_clk),
		.resetn_in(resetn_in),
		.in_valid_in(state_r == DSS_PUSH),
		.in_data_in(word_r),
		.in_ready_out(fifo_ready),
		.out_valid_out(link.res_valid),
		.out_data_out(link.res_word),
		.out_ready_in(link.res_ready)
	);
endmodule : dss_device
`default_nettype wire

// >>> design/dss_pkg.sv
package dss_pkg;
	// ==========================================
	// Sizes and codes
	localparam int DSS_BITS = 16;
	localparam int DSS_CHANS = 2;
	localparam int DSS_SPAN_W = 3;
	localparam int DSS_CFG_W = 6;
	localparam int DSS_FIFO_W = 19;
	localparam int DSS_FIFO_D = 16;
	localparam logic [2:0] DSS_SPAN_OFF = 3'h0;
	localparam logic [15:0] DSS_RESET_CODE = 16'h0000;
	localparam logic [5:0] DSS_RESET_CFG = 6'h3f;
	// Result words per conversion; also the host's idle count
	localparam logic [1:0] DSS_WORDS = 2'h2;
	// Search starts at the top weight
	localparam logic [3:0] DSS_TOP_BIT = 4'hf;
	localparam logic [15:0] DSS_FIRST_TRIAL = 16'h8000;
	// Link clock divider: host core clock cycles per link phase
	localparam int DSS_LINK_DIV = 2;
	// Result word: span code in [18:16], code in [15:0]
	localparam int DSS_WORD_SPAN_LSB = 16;

	typedef enum logic [2:0] {
		DSS_IDLE = 3'b000,
		DSS_SAMPLE = 3'b001,
		DSS_CONVERT = 3'b010,
		DSS_FORMAT = 3'b011,
		DSS_PUSH = 3'b100,
		DSS_SLEEP = 3'b101
	} dss_state_e;

	// Bipolar when code is 7, 6, 3 or 2
	function automatic logic dss_is_bipolar(input logic [2:0] span);
		return span[1];
	endfunction : dss_is_bipolar

	// Offset binary search result to output format
	function automatic logic [15:0] dss_format(input logic [2:0] span, input logic [15:0] raw);
		if (span == DSS_SPAN_OFF) begin
			return DSS_RESET_CODE;
		end
		return dss_is_bipolar(span) ? {~raw[15], raw[14:0]} : raw;
	endfunction : dss_format
endpackage : dss_pkg

// >>> design/dss_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dss_link_if;
	logic link_clk;
	logic conv_start;
	logic power_down;
	logic lvds_mode;
	logic two_lanes;
	logic cfg_valid;
	logic [5:0] cfg_word;
	logic res_valid;
	logic [18:0] res_word;
	logic res_ready;
	logic busy;
	modport dev (input link_clk, conv_start, power_down, lvds_mode, two_lanes, cfg_valid, cfg_word, res_ready,
		output res_valid, res_word, busy);
	modport host (output link_clk, conv_start, power_down, lvds_mode, two_lanes, cfg_valid, cfg_word, res_ready,
		input res_valid, res_word, busy);
endinterface : dss_link_if
`default_nettype wire

// >>> design/dss_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module dss_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Fill side
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	// Drain side
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	assign in_ready_out = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid_out = (cnt_r != '0);
	assign out_data_out = mem_r[rp_r];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_r[wp_r] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : dss_fifo
`default_nettype wire

// >>> design/dss_host.sv
`timescale 1ns/1ps
`default_nettype none
module dss_host
	import dss_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic resetn_in,
	// Link to device
	dss_link_if.host link,
	// User control
	input wire logic start_in,
	input wire logic [2:0] span0_in,
	input wire logic [2:0] span1_in,
	input wire logic sleep_in,
	input wire logic lvds_in,
	input wire logic two_lanes_in,
	// User results
	output logic result_valid_out,
	output logic result_chan_out,
	output logic [2:0] result_span_out,
	output logic [15:0] result_code_out,
	output logic ready_out
);
	// ==========================================
	// Link clock made by division
	logic [3:0] div_r;
	logic lclk_r;

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			div_r <= '0;
			lclk_r <= 1'b0;
		end else if (div_r == 4'(DSS_LINK_DIV - 1)) begin
			div_r <= '0;
			lclk_r <= !lclk_r;
		end else begin
			div_r <= div_r + 4'h1;
		end
	end
	assign link.link_clk = lclk_r;

	// ==========================================
	// Control outputs; the link clock is derived, so conv_start and cfg_valid change only on a falling link edge
	logic fall;
	logic [1:0] busy_s_r;
	logic pend_r;
	logic cnv_r;
	logic cfg_v_r;
	logic [5:0] cfg_r;
	logic [1:0] got_r;

	assign fall = lclk_r && div_r == 4'(DSS_LINK_DIV - 1);

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			busy_s_r <= '0;
		end else begin
			busy_s_r <= {busy_s_r[0], link.busy};
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pend_r <= 1'b0;
			cnv_r <= 1'b0;
			cfg_v_r <= 1'b0;
			cfg_r <= DSS_RESET_CFG;
			got_r <= DSS_WORDS;
		end else begin
			if (start_in && ready_out) begin
				pend_r <= 1'b1;
				cfg_r <= {span1_in, span0_in};
				got_r <= '0;
			end
			if (fall) begin
				if (pend_r && !cfg_v_r && !cnv_r) begin
					cfg_v_r <= 1'b1;
				end else if (cfg_v_r) begin
					cfg_v_r <= 1'b0;
					cnv_r <= 1'b1;
				end else if (cnv_r) begin
					cnv_r <= 1'b0;
					pend_r <= 1'b0;
				end
			end
			if (link.res_valid && link.res_ready && fall) begin
				got_r <= got_r + 2'h1;
			end
		end
	end

	// Next start waits until both words of the last one arrived; the count stays below two from the
	// Start on, so ready cannot reopen in the gap before the synchronised busy arrives
	assign ready_out = !pend_r && !busy_s_r[1] && got_r == DSS_WORDS && !sleep_in;
	assign link.conv_start = cnv_r;
	assign link.cfg_valid = cfg_v_r;
	assign link.cfg_word = cfg_r;
	assign link.power_down = sleep_in && !pend_r && !busy_s_r[1] && got_r == DSS_WORDS;
	assign link.lvds_mode = lvds_in;
	assign link.two_lanes = two_lanes_in;
	assign link.res_ready = 1'b1;

	// ==========================================
	// Result capture, channel 0 arrives first
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			result_valid_out <= 1'b0;
			result_chan_out <= 1'b0;
			result_span_out <= '0;
			result_code_out <= '0;
		end else begin
			result_valid_out <= link.res_valid && fall;
			if (link.res_valid && fall) begin
				result_chan_out <= got_r[0];
				result_span_out <= link.res_word[18:DSS_WORD_SPAN_LSB];
				result_code_out <= link.res_word[15:0];
			end
		end
	end
endmodule : dss_host
`default_nettype wire

// >>> sim/dss_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dss_assertions (
	// Link signals
	input wire logic link_clk,
	input wire logic resetn_in,
	input wire logic conv_start,
	input wire logic power_down,
	input wire logic cfg_valid,
	input wire logic [5:0] cfg_word,
	input wire logic res_valid,
	input wire logic [18:0] res_word,
	input wire logic res_ready,
	input wire logic busy
);
	// ==========================================
	// Helpers
	logic [5:0] cfg_r;
	logic [7:0] busy_cnt_r;
	logic [1:0] push_cnt_r;
	wire logic push = res_valid && res_ready;
	// Time the enabled channels need at least: one search step per bit for each
	wire logic [5:0] need = {(|cfg_r[2:0]) && (|cfg_r[5:3]), (|cfg_r[2:0]) ^ (|cfg_r[5:3]), 4'h0};
	always_ff @(posedge link_clk or negedge resetn_in) begin
		if (!resetn_in) begin
			cfg_r <= 6'h3f;
		end else if (cfg_valid) begin
			cfg_r <= cfg_word;
		end
	end
	always_ff @(posedge link_clk or negedge resetn_in) begin
		if (!resetn_in) begin
			busy_cnt_r <= 8'h00;
		end else begin
			busy_cnt_r <= busy ? busy_cnt_r + 8'h01 : 8'h00;
		end
	end
	// The second word leaves the queue on the edge at which busy is first seen low
	always_ff @(posedge link_clk or negedge resetn_in) begin
		if (!resetn_in) begin
			push_cnt_r <= 2'h0;
		end else if (push) begin
			push_cnt_r <= push_cnt_r + 2'h1;
		end else if (!busy) begin
			push_cnt_r <= 2'h0;
		end
	end
	// ==========================================
	// Properties
	default clocking cb @(posedge link_clk); endclocking
	default disable iff (!resetn_in);
	property p_res_hold; res_valid && !res_ready |=> res_valid && $stable(res_word); endproperty
	property p_start; $rose(conv_start) && !busy |-> ##[1:8] busy; endproperty
	property p_off_zero; push && res_word[18:16] == 3'h0 |-> res_word[15:0] == 16'h0000; endproperty
	property p_min_time; $fell(busy) |-> busy_cnt_r >= {2'h0, need}; endproperty
	property p_two; $fell(busy) |=> push_cnt_r == 2'h2; endproperty
	property p_first; push && push_cnt_r == 2'h0 |-> res_word[18:16] == cfg_r[2:0]; endproperty
	property p_second; push && push_cnt_r == 2'h1 |-> res_word[18:16] == cfg_r[5:3]; endproperty
	property p_sleep; $rose(power_down) |-> !busy; endproperty
	property p_done; $rose(busy) |-> ##[1:200] !busy; endproperty
	a_res_hold: assert property (p_res_hold) else $error("result word changed before taken");
	a_start: assert property (p_start) else $error("start edge did not begin conversion");
	a_off_zero: assert property (p_off_zero) else $error("disabled channel code not zero");
	a_min_time: assert property (p_min_time) else $error("conversion shorter than search");
	a_two: assert property (p_two) else $error("busy ended without two results");
	a_first: assert property (p_first) else $error("first word is not channel 0");
	a_second: assert property (p_second) else $error("second word span wrong");
	a_sleep: assert property (p_sleep) else $error("sleep entered while converting");
	a_done: assert property (p_done) else $error("conversion did not end");
	c_done: cover property ($fell(busy));
	c_off: cover property (push && res_word[18:16] == 3'h0);
	c_sleep: cover property ($rose(power_down));
endmodule : dss_assertions
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import dss_pkg::*;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic start = 1'b0, sleep = 1'b0, lvds = 1'b0, two = 1'b0;
	logic [2:0] span0 = 3'h0, span1 = 3'h0;
	logic [15:0] h0 = 16'h0000, h1 = 16'h0000;
	logic rv, rch, rdy, trk, aon, lsel, dsel;
	logic [2:0] rsp;
	logic [15:0] rcode;
	int compares = 0;
	int miscompares = 0;
	always #20 core_clk = ~core_clk;
	dss_link_if link();
	dss_host i_dss_host (.core_clk_in(core_clk), .resetn_in(resetn), .link(link), .start_in(start),
		.span0_in(span0), .span1_in(span1), .sleep_in(sleep), .lvds_in(lvds), .two_lanes_in(two),
		.result_valid_out(rv), .result_chan_out(rch), .result_span_out(rsp), .result_code_out(rcode),
		.ready_out(rdy));
	dss_device i_dss_device (.link(link), .resetn_in(resetn), .held_ch0_in(h0), .held_ch1_in(h1),
		.track_out(trk), .dac_code_out(), .dac_chan_out(), .analog_on_out(aon), .lvds_sel_out(lsel),
		.dual_lane_out(dsel));
	dss_assertions u_chk (.link_clk(link.link_clk), .resetn_in(resetn), .conv_start(link.conv_start),
		.power_down(link.power_down), .cfg_valid(link.cfg_valid), .cfg_word(link.cfg_word),
		.res_valid(link.res_valid), .res_word(link.res_word), .res_ready(link.res_ready), .busy(link.busy));
	// ==========================================
	// Tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic results();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results
	// Expected code worked out from the span table, not from the design
	function automatic logic [15:0] expect_code(input logic [2:0] s, input logic [15:0] v);
		if (s == 3'h0) begin
			return 16'h0000;
		end
		return (s inside {3'h7, 3'h6, 3'h3, 3'h2}) ? {~v[15], v[14:0]} : v;
	endfunction : expect_code
	task automatic run(input logic [2:0] s0, input logic [2:0] s1, input logic [15:0] v0, input logic [15:0] v1);
		int n;
		logic held_seen;
		logic [2:0] sp[2];
		logic [15:0] v[2];
		sp[0] = s0;
		sp[1] = s1;
		v[0] = v0;
		v[1] = v1;
		held_seen = 1'b0;
		@(posedge core_clk);
		span0 <= s0;
		span1 <= s1;
		h0 <= v0;
		h1 <= v1;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (rdy !== 1'b1 && n < 4000);
		chk({15'h0000, rdy}, 16'h0001);
		@(posedge core_clk);
		start <= 1'b1;
		@(posedge core_clk);
		start <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(negedge core_clk);
				held_seen |= (trk === 1'b0);
				n++;
			end while (rv !== 1'b1 && n < 3000);
			chk({15'h0000, rv}, 16'h0001);
			chk({15'h0000, rch}, k[15:0]);
			chk({13'h0000, rsp}, {13'h0000, sp[k]});
			chk(rcode, expect_code(sp[k], v[k]));
		end
		chk({15'h0000, held_seen}, 16'h0001);
	endtask : run
	// ==========================================
	// Sequence
	initial begin
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk({15'h0000, trk}, 16'h0001);
		for (int p = 0; p < 2; p++) begin
			lvds <= p[0];
			two <= ~p[0];
			repeat (40) @(posedge core_clk);
			chk({14'h0000, lsel, dsel}, {14'h0000, p[0], ~p[0]});
		end
		// Every span code on each channel, back to back, channel 0 in the top eight codes up to full scale, channel 1 in steps of 2000 hex
		for (int s = 0; s < 8; s++) begin
			run(s[2:0], 3'h7 - s[2:0], 16'hfff8 + s[15:0], {s[2:0], 13'h0000});
		end
		run(3'h0, 3'h0, 16'h1234, 16'h4321);
		repeat (200) @(posedge core_clk);
		sleep <= 1'b1;
		repeat (80) @(posedge core_clk);
		chk({15'h0000, aon}, 16'h0000);
		sleep <= 1'b0;
		repeat (80) @(posedge core_clk);
		chk({15'h0000, aon}, 16'h0001);
		run(3'h3, 3'h1, 16'h0000, 16'h7fff);
		results();
	end
	initial begin
		#(40 * 40000);
		miscompares++;
		results();
	end
endmodule : tb_top
`default_nettype wire
